// ---- tb/cso_core_tb_top.sv ----
// Self-checking bench for the stack and special-operation core
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module cso_core_tb_top;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clock = 0, resetn = 0, cmd_valid = 0, cmd_round_off = 0, mem_ack = 0;
    logic [3:0] cmd_op = 0;
    logic [1:0] cmd_size = 0;
    logic [2:0] cmd_reg = 0, irq_level = 0;
    logic [31:0] cmd_data = 0, cmd_pc = 0, mem_rdata = 0;
    logic [15:0] cmd_imm = 0;
    logic cmd_ready, done, trap_taken, low_power, mem_req, mem_we, tr;
    logic [31:0] result, mem_addr, mem_wdata, a_prev, a_last, d_last;
    logic [7:0] result_frac;
    logic [15:0] status;
    logic [1:0] mem_size, s_last;
    int failures = 0, checks_done = 0, cyc = 0;
    logic [40:0] rows [7] = '{{4'h6, 2'h0, 3'h0, 32'hFFFF_FFFF}, {4'h7, 2'h0, 3'h0, 32'hFFFF_FFFF},
        {4'hA, 2'h0, 3'h0, 32'h0000_0000}, {4'h6, 2'h1, 3'h1, 32'hFFFF_FFFE},
        {4'h6, 2'h2, 3'h6, 32'hFFFF_FFFC}, {4'h7, 2'h2, 3'h6, 32'hFFFF_FFFC},
        {4'hA, 2'h0, 3'h6, 32'h0000_0000}};
    cso_core cso_core_i (.clock(clock), .resetn(resetn), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_size(cmd_size), .cmd_reg(cmd_reg),
        .cmd_data(cmd_data), .cmd_pc(cmd_pc), .cmd_imm(cmd_imm), .cmd_round_off(cmd_round_off),
        .done(done), .trap_taken(trap_taken), .result(result), .result_frac(result_frac),
        .status(status), .low_power(low_power), .irq_level(irq_level), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_size(mem_size),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    // ----------------------------------------
    // Clock, memory responder, hang limit
    // ----------------------------------------
    initial forever #10 clock = ~clock;
    always @(posedge clock) begin
        mem_ack <= mem_req && !mem_ack;
        mem_rdata <= mem_addr - 32'h0000_00F2;
        if (mem_req && mem_ack) begin
            a_prev <= a_last;
            a_last <= mem_addr;
            d_last <= mem_wdata;
            s_last <= mem_size;
        end
        cyc++;
        if (cyc == 20000) begin
            failures++;
            test_done();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic test_done;
        if (failures == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic issue(input logic [3:0] op, input logic [1:0] sz, input logic [2:0] rg,
        input logic [31:0] dat, input logic [15:0] imm, input logic ro);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_size <= sz;
        cmd_reg <= rg;
        cmd_data <= dat;
        cmd_pc <= dat;
        cmd_imm <= imm;
        cmd_round_off <= ro;
        do @(posedge clock); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
    endtask
    task automatic wait_done;
        do @(posedge clock); while (done !== 1'b1);
        tr = trap_taken;
    endtask
    task automatic cmd(input logic [3:0] op, input logic [1:0] sz, input logic [2:0] rg,
        input logic [31:0] dat, input logic [15:0] imm, input logic ro);
        issue(op, sz, rg, dat, imm, ro);
        wait_done();
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        `CHK(status, 16'h2700)
        `CHK(low_power, 1'b0)
        repeat (3) @(posedge clock);
        foreach (rows[i]) begin
            cmd(rows[i][40:37], rows[i][36:35], rows[i][34:32], 0, 0, 0);
            `CHK(result, rows[i][31:0])
        end
        cmd(4'h1, 2'h0, 0, 32'h0000_00AB, 0, 0);
        `CHK({a_last, d_last[15:8], s_last}, {32'hFFFF_FFFE, 8'hAB, 2'h0})
        cmd(4'h1, 2'h2, 0, 32'h1234_5678, 0, 0);
        `CHK({a_last, d_last}, {32'hFFFF_FFFA, 32'h1234_5678})
        cmd(4'hA, 0, 3'h7, 0, 0, 0);
        `CHK(result, 32'hFFFF_FFFA)
        cmd(4'h2, 2'h2, 0, 0, 0, 0);
        `CHK(result, 32'hFFFF_FF08)
        cmd(4'h2, 2'h0, 0, 0, 0, 0);
        `CHK({a_last, result}, {32'hFFFF_FFFE, 32'h0000_00FF})
        cmd(4'h3, 0, 0, 32'h0000_1000, 0, 0);
        `CHK({a_last, d_last}, {32'hFFFF_FFFC, 32'h0000_1000})
        cmd(4'h4, 0, 0, 0, 0, 0);
        `CHK({a_last, result}, {32'hFFFF_FFFC, 32'hFFFF_FF0A})
        cmd(4'h5, 0, 0, 32'h0000_2000, 0, 0);
        `CHK({tr, a_prev, a_last, d_last[15:0]}, {1'b1, 64'hFFFF_FFFC_FFFF_FFFA, 16'h2700})
        cmd(4'hB, 0, 0, 0, 0, 0);
        `CHK({tr, a_last}, {1'b1, 32'hFFFF_FFF4})
        irq_level <= 3'h2;
        issue(4'h8, 0, 0, 0, 16'h0300, 0);
        repeat (12) @(posedge clock);
        `CHK({low_power, status, cmd_ready}, {1'b1, 16'h0300, 1'b0})
        irq_level <= 3'h3;
        wait_done();
        `CHK(low_power, 1'b0)
        irq_level <= 3'h0;
        cmd(4'hA, 0, 3'h7, 0, 0, 0);
        `CHK(result, 32'h0000_0000)
        cmd(4'h1, 2'h1, 0, 32'h0000_5555, 0, 0);
        `CHK(a_last, 32'hFFFF_FFFE)
        cmd(4'h8, 0, 0, 32'h0000_3000, 16'h2700, 0);
        `CHK({tr, a_prev, a_last}, {1'b1, 64'hFFFF_FFF0_FFFF_FFEE})
        `CHK({status, d_last[15:0]}, {16'h2300, 16'h0300})
        cmd(4'h9, 2'h1, 0, 32'h0000_0100, 16'h0140, 0);
        `CHK({a_prev, a_last, result}, {64'h0000_0102_0000_0104, 32'h0000_0011})
        cmd(4'h9, 2'h1, 0, 32'h0000_0100, 16'h0140, 1);
        `CHK({result, result_frac}, {32'h0000_0010, 8'h80})
        cmd(4'h9, 2'h2, 0, 32'h0000_0100, 16'h0200, 1);
        `CHK({a_prev, a_last, result, result_frac}, {64'h0000_0108_0000_010C, 40'h16_00})
        issue(4'h8, 0, 0, 0, 16'h2700, 0);
        repeat (4) @(posedge clock);
        `CHK(low_power, 1'b1)
        resetn <= 1'b0;
        @(posedge clock);
        `CHK({low_power, status, cmd_ready}, {1'b0, 16'h2700, 1'b1})
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        cmd(4'hA, 0, 3'h7, 0, 0, 0);
        `CHK(result, 32'h0000_0000)
        test_done();
    end
endmodule

// ---- verilog/cso_core.sv ----
// Banked stack pointer, address modes, low-power halt, table interpolate, trap sequencer
// Function
// - register seven is the active bank's stack pointer
// - inactive bank pointer is never reachable
// - stack grows downward; predecrement pushes, postincrement pulls
// - calls push return address; returns pull it
// - traps stack address and status on supervisor stack
// - stack bytes sit in word high half
// - predecrement before use, postincrement after use
// - low-power halt until qualifying interrupt or reset
// - interpolate linearly between two fetched table entries
// - round to nearest unless unrounded fraction requested for byte or word entries; long entries always rounded
// - unimplemented command codes take a trap
// - halt loads status in supervisor; traps in user
`timescale 1ns/100ps
module cso_core (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Command from the instruction stream
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [3:0] cmd_op,
    input wire logic [1:0] cmd_size,
    input wire logic [2:0] cmd_reg,
    input wire logic [31:0] cmd_data,
    input wire logic [31:0] cmd_pc,
    input wire logic [15:0] cmd_imm,
    input wire logic cmd_round_off,
    // Answer
    output logic done,
    output logic trap_taken,
    output logic [31:0] result,
    output logic [7:0] result_frac,
    // Processor state
    output logic [15:0] status,
    output logic low_power,
    input wire logic [2:0] irq_level,
    // Memory port
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic [1:0] mem_size,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);

    // ------------------------------------------------------------
    // Reset release and interrupt level input
    // ------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [2:0] irq_s1_r, irq_s2_r, irq_s3_r, irq_lvl_r;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) rst_sync_r <= 2'h0;
        else rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_s1_r <= 3'h0;
            irq_s2_r <= 3'h0;
            irq_s3_r <= 3'h0;
            irq_lvl_r <= 3'h0;
        end else begin
            irq_s1_r <= irq_level;
            irq_s2_r <= irq_s1_r;
            irq_s3_r <= irq_s2_r;
            if (irq_s2_r == irq_s3_r) irq_lvl_r <= irq_s3_r;
        end
    end

    // ------------------------------------------------------------
    // State and decode
    // ------------------------------------------------------------
    cso_pkg::cso_state_e st_r, st_nxt;
    cso_pkg::cso_op_e op_r, op_nxt, op_eff;
    logic [31:0] an_r [0:cso_pkg::AREG_NUM-1];
    logic [15:0] sr_r, sr_nxt;
    logic sup, unimpl, stop_user, accept, wake, stack_op, call_ret, byte_hi;
    logic [2:0] ptr_reg;
    logic [3:0] act_idx;
    logic [1:0] sz_eff;
    logic [31:0] ptr, step, dec_ptr, inc_ptr, push_data, sup_dec4, sup_dec2;
    logic [31:0] ent_step, ent_a0, ent_a1, ent_a1_r, ent_a1_nxt, y0_r, y0_nxt, y_rd;
    logic [7:0] frac_r, frac_nxt;
    logic [1:0] tsz_r, tsz_nxt;
    logic rnd_off_r, rnd_off_nxt;

    assign sup = sr_r[cso_pkg::SR_S_BIT];
    assign unimpl = cmd_op > cso_pkg::OP_LAST;
    assign stop_user = (cmd_op == cso_pkg::OP_LOW_POWER_HALT) && !sup;
    assign op_eff = (unimpl || stop_user) ? cso_pkg::OP_TRAP : cso_pkg::cso_op_e'(cmd_op);
    assign accept = (st_r == cso_pkg::ST_IDLE) && cmd_valid;
    assign cmd_ready = (st_r == cso_pkg::ST_IDLE);
    assign stack_op = op_eff inside {cso_pkg::OP_PUSH, cso_pkg::OP_PULL,
                                     cso_pkg::OP_CALL, cso_pkg::OP_RET};
    assign call_ret = op_eff inside {cso_pkg::OP_CALL, cso_pkg::OP_RET};
    assign ptr_reg = stack_op ? cso_pkg::REG_STACK_PTR : cmd_reg;
    // Index seven selects the bank chosen by the supervisor bit
    assign act_idx = (ptr_reg != cso_pkg::REG_STACK_PTR) ? {1'b0, ptr_reg} :
                     sup ? cso_pkg::IDX_SUPERVISOR_PTR : cso_pkg::IDX_USER_PTR;
    assign ptr = an_r[act_idx];
    assign sz_eff = call_ret ? cso_pkg::SZ_L : cmd_size;
    assign step = (sz_eff == cso_pkg::SZ_L) ? cso_pkg::STEP_L :
                  (sz_eff == cso_pkg::SZ_W) ? cso_pkg::STEP_W :
                  (ptr_reg == cso_pkg::REG_STACK_PTR) ? cso_pkg::STEP_W : cso_pkg::STEP_B;
    assign dec_ptr = ptr - step;
    assign inc_ptr = ptr + step;
    assign byte_hi = (ptr_reg == cso_pkg::REG_STACK_PTR) && (sz_eff == cso_pkg::SZ_B);
    assign push_data = (op_eff == cso_pkg::OP_CALL) ? cmd_pc :
                       byte_hi ? {16'h0000, cmd_data[7:0], 8'h00} : cmd_data;
    assign sup_dec4 = an_r[cso_pkg::IDX_SUPERVISOR_PTR] - cso_pkg::STEP_L;
    assign sup_dec2 = an_r[cso_pkg::IDX_SUPERVISOR_PTR] - cso_pkg::STEP_W;
    assign ent_step = (cmd_size == cso_pkg::SZ_L) ? cso_pkg::STEP_L :
                      (cmd_size == cso_pkg::SZ_W) ? cso_pkg::STEP_W : cso_pkg::STEP_B;
    assign ent_a0 = cmd_data + 32'(ent_step * {24'h000000, cmd_imm[15:8]});
    assign ent_a1 = ent_a0 + ent_step;
    assign y_rd = (tsz_r == cso_pkg::SZ_L) ? mem_rdata :
                  (tsz_r == cso_pkg::SZ_W) ? {{16{mem_rdata[15]}}, mem_rdata[15:0]}
                                           : {{24{mem_rdata[7]}}, mem_rdata[7:0]};
    assign wake = (irq_lvl_r != 3'h0) &&
                  (irq_lvl_r >= sr_r[cso_pkg::SR_MASK_LO +: 3]);

    // ------------------------------------------------------------
    // Address register file
    // ------------------------------------------------------------
    logic wr_en;
    logic [3:0] wr_idx;
    logic [31:0] wr_val;
    for (genvar i = 0; i < cso_pkg::AREG_NUM; i++) begin : g_areg
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) an_r[i] <= cso_pkg::AREG_RST;
            else if (wr_en && wr_idx == 4'(i)) an_r[i] <= wr_val;
        end
    end

    // ------------------------------------------------------------
    // Interpolator
    // ------------------------------------------------------------
    logic ip_start, ip_done;
    logic [31:0] ip_result;
    logic [7:0] ip_frac;
    cso_interp cso_interp_i (
        .clock(clock),
        .rst_n(rst_n),
        .start(ip_start),
        .y0(y0_r),
        .y1(y_rd),
        .frac(frac_r),
        .size(tsz_r),
        .round_off(rnd_off_r),
        .done(ip_done),
        .result(ip_result),
        .frac_out(ip_frac)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    logic req_nxt, we_nxt, done_nxt, trap_nxt;
    logic [31:0] addr_nxt, wdata_nxt, res_nxt;
    logic [1:0] size_nxt;
    logic [7:0] rfrac_nxt;
    always_comb begin
        st_nxt = st_r;
        op_nxt = op_r;
        sr_nxt = sr_r;
        req_nxt = mem_req;
        we_nxt = mem_we;
        addr_nxt = mem_addr;
        wdata_nxt = mem_wdata;
        size_nxt = mem_size;
        done_nxt = 1'b0;
        trap_nxt = 1'b0;
        res_nxt = result;
        rfrac_nxt = result_frac;
        y0_nxt = y0_r;
        ent_a1_nxt = ent_a1_r;
        frac_nxt = frac_r;
        tsz_nxt = tsz_r;
        rnd_off_nxt = rnd_off_r;
        ip_start = 1'b0;
        wr_en = 1'b0;
        wr_idx = act_idx;
        wr_val = dec_ptr;
        case (st_r)
            cso_pkg::ST_IDLE: begin
                if (cmd_valid) begin
                    op_nxt = op_eff;
                    size_nxt = sz_eff;
                    case (op_eff)
                        cso_pkg::OP_PUSH, cso_pkg::OP_CALL: begin
                            wr_en = 1'b1;
                            {req_nxt, we_nxt, addr_nxt, wdata_nxt} = {2'h3, dec_ptr, push_data};
                            st_nxt = cso_pkg::ST_MEM1;
                        end
                        cso_pkg::OP_PULL, cso_pkg::OP_RET: begin
                            wr_en = 1'b1;
                            wr_val = inc_ptr;
                            {req_nxt, we_nxt, addr_nxt} = {2'h2, ptr};
                            st_nxt = cso_pkg::ST_MEM1;
                        end
                        cso_pkg::OP_PRE: begin
                            wr_en = 1'b1;
                            res_nxt = dec_ptr;
                            done_nxt = 1'b1;
                        end
                        cso_pkg::OP_POST: begin
                            wr_en = 1'b1;
                            wr_val = inc_ptr;
                            res_nxt = ptr;
                            done_nxt = 1'b1;
                        end
                        cso_pkg::OP_READ, cso_pkg::OP_NOP: begin
                            res_nxt = ptr;
                            done_nxt = 1'b1;
                        end
                        cso_pkg::OP_LOW_POWER_HALT: begin
                            sr_nxt = cmd_imm;
                            st_nxt = cso_pkg::ST_STOP;
                        end
                        cso_pkg::OP_TABLE_INTERPOLATE: begin
                            {req_nxt, we_nxt, addr_nxt} = {2'h2, ent_a0};
                            ent_a1_nxt = ent_a1;
                            frac_nxt = cmd_imm[7:0];
                            tsz_nxt = cmd_size;
                            rnd_off_nxt = cmd_round_off;
                            st_nxt = cso_pkg::ST_MEM1;
                        end
                        default: begin
                            wr_en = 1'b1;
                            wr_idx = cso_pkg::IDX_SUPERVISOR_PTR;
                            wr_val = sup_dec4;
                            {req_nxt, we_nxt, addr_nxt, wdata_nxt} = {2'h3, sup_dec4, cmd_pc};
                            size_nxt = cso_pkg::SZ_L;
                            st_nxt = cso_pkg::ST_MEM1;
                        end
                    endcase
                end
            end
            cso_pkg::ST_MEM1: begin
                if (mem_ack) begin
                    req_nxt = 1'b0;
                    st_nxt = cso_pkg::ST_IDLE;
                    done_nxt = 1'b1;
                    if (op_r == cso_pkg::OP_TRAP) begin
                        wr_en = 1'b1;
                        wr_idx = cso_pkg::IDX_SUPERVISOR_PTR;
                        wr_val = sup_dec2;
                        {req_nxt, we_nxt, addr_nxt, wdata_nxt} = {2'h3, sup_dec2, 16'h0000, sr_r};
                        size_nxt = cso_pkg::SZ_W;
                        done_nxt = 1'b0;
                        st_nxt = cso_pkg::ST_MEM2;
                    end else if (op_r == cso_pkg::OP_TABLE_INTERPOLATE) begin
                        y0_nxt = y_rd;
                        {req_nxt, addr_nxt} = {1'b1, ent_a1_r};
                        done_nxt = 1'b0;
                        st_nxt = cso_pkg::ST_MEM2;
                    end else if (op_r == cso_pkg::OP_PULL && mem_size == cso_pkg::SZ_B) begin
                        res_nxt = {24'h000000, mem_rdata[15:8]};
                    end else if (!mem_we) begin
                        res_nxt = mem_rdata;
                    end
                end
            end
            cso_pkg::ST_MEM2: begin
                if (mem_ack) begin
                    req_nxt = 1'b0;
                    if (op_r == cso_pkg::OP_TRAP) begin
                        sr_nxt[cso_pkg::SR_S_BIT] = 1'b1;
                        trap_nxt = 1'b1;
                        done_nxt = 1'b1;
                        st_nxt = cso_pkg::ST_IDLE;
                    end else begin
                        ip_start = 1'b1;
                        st_nxt = cso_pkg::ST_CALC;
                    end
                end
            end
            cso_pkg::ST_CALC: begin
                if (ip_done) begin
                    res_nxt = ip_result;
                    rfrac_nxt = ip_frac;
                    done_nxt = 1'b1;
                    st_nxt = cso_pkg::ST_IDLE;
                end
            end
            cso_pkg::ST_STOP: begin
                if (wake) begin
                    done_nxt = 1'b1;
                    st_nxt = cso_pkg::ST_IDLE;
                end
            end
            default: st_nxt = cso_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= cso_pkg::ST_IDLE;
            op_r <= cso_pkg::OP_NOP;
            sr_r <= cso_pkg::SR_RST;
            {mem_req, mem_we, mem_size, done, trap_taken} <= 6'h00;
            {mem_addr, mem_wdata, result, y0_r, ent_a1_r} <= 160'h0;
            {result_frac, frac_r, tsz_r, rnd_off_r} <= 19'h00000;
        end else begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            sr_r <= sr_nxt;
            {mem_req, mem_we, mem_size, done, trap_taken} <=
                {req_nxt, we_nxt, size_nxt, done_nxt, trap_nxt};
            {mem_addr, mem_wdata, result, y0_r, ent_a1_r} <=
                {addr_nxt, wdata_nxt, res_nxt, y0_nxt, ent_a1_nxt};
            {result_frac, frac_r, tsz_r, rnd_off_r} <= {rfrac_nxt, frac_nxt, tsz_nxt, rnd_off_nxt};
        end
    end

    assign status = sr_r;
    assign low_power = (st_r == cso_pkg::ST_STOP);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sup_push_a: assert property (
        (accept && op_eff == cso_pkg::OP_PUSH && sup) |=>
        an_r[cso_pkg::IDX_SUPERVISOR_PTR] == $past(dec_ptr) &&
        mem_addr == an_r[cso_pkg::IDX_SUPERVISOR_PTR])
        else $error("supervisor push missed its pointer");
    user_hidden_a: assert property (
        (accept && op_eff == cso_pkg::OP_PUSH && sup) |=>
        an_r[cso_pkg::IDX_USER_PTR] == $past(an_r[cso_pkg::IDX_USER_PTR]))
        else $error("user pointer moved in supervisor state");
    // Modular distance, so a push from address zero still counts as downward
    stack_down_a: assert property (
        (accept && op_eff == cso_pkg::OP_PUSH) |=> mem_req && mem_we &&
        ($past(ptr) - mem_addr) inside {32'h0000_0002, 32'h0000_0004})
        else $error("push did not move downward");
    call_push_a: assert property (
        (accept && op_eff == cso_pkg::OP_CALL) |=>
        mem_we && mem_wdata == $past(cmd_pc) && mem_size == cso_pkg::SZ_L)
        else $error("call did not stack return address");
    trap_frame_a: assert property (
        (accept && op_eff == cso_pkg::OP_TRAP) |=>
        an_r[cso_pkg::IDX_SUPERVISOR_PTR] == $past(sup_dec4) && mem_addr == $past(sup_dec4))
        else $error("trap did not use supervisor stack");
    byte_align_a: assert property (
        (accept && op_eff == cso_pkg::OP_PUSH && cmd_size == cso_pkg::SZ_B) |=>
        mem_addr == $past(ptr) - 32'h2 && mem_wdata[7:0] == 8'h00)
        else $error("stack byte push misaligned");
    post_inc_a: assert property (
        (accept && op_eff == cso_pkg::OP_POST && cmd_reg != cso_pkg::REG_STACK_PTR) |=>
        done && result == $past(ptr) && an_r[$past(act_idx)] == $past(inc_ptr))
        else $error("postincrement used the wrong address");
    stop_hold_a: assert property (
        (st_r == cso_pkg::ST_STOP && !wake) |=> st_r == cso_pkg::ST_STOP && !done)
        else $error("halt left without interrupt");
    unimpl_trap_a: assert property (
        (accept && unimpl) |=> op_r == cso_pkg::OP_TRAP && st_r == cso_pkg::ST_MEM1)
        else $error("unimplemented code not trapped");
    halt_user_a: assert property (
        (accept && stop_user) |=> st_r != cso_pkg::ST_STOP && sr_r == $past(sr_r))
        else $error("user halt did not trap");
    interp_end_a: assert property (
        (st_r == cso_pkg::ST_MEM2 && mem_ack && op_r == cso_pkg::OP_TABLE_INTERPOLATE) |=>
        st_r == cso_pkg::ST_CALC ##1 done)
        else $error("interpolation did not finish");

    trap_seen_c: cover property (trap_taken);
    wake_seen_c: cover property (st_r == cso_pkg::ST_STOP ##1 st_r == cso_pkg::ST_IDLE);
    interp_seen_c: cover property (st_r == cso_pkg::ST_CALC ##1 done);

endmodule

// ---- verilog/cso_interp.sv ----
// Linear interpolation datapath between two table entries
`timescale 1ns/100ps
module cso_interp (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Request
    input wire logic start,
    input wire logic [31:0] y0,
    input wire logic [31:0] y1,
    input wire logic [7:0] frac,
    input wire logic [1:0] size,
    input wire logic round_off,
    // Answer
    output logic done,
    output logic [31:0] result,
    output logic [7:0] frac_out
);

    // ------------------------------------------------------------
    // Arithmetic: y0 + (y1 - y0) * frac / 256
    // ------------------------------------------------------------
    logic signed [32:0] diff;
    logic signed [41:0] prod;
    logic signed [41:0] prod_rnd;
    logic signed [33:0] step_q;
    logic keep_frac;
    assign diff = $signed({y1[31], y1}) - $signed({y0[31], y0});
    assign prod = 42'(diff) * 42'($signed({1'b0, frac}));
    // Long results are always rounded
    assign keep_frac = round_off && (size != cso_pkg::SZ_L);
    assign prod_rnd = keep_frac ? prod : prod + 42'(cso_pkg::ROUND_HALF);
    assign step_q = 34'(prod_rnd >>> cso_pkg::FRAC_W);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
            result <= 32'h0000_0000;
            frac_out <= 8'h00;
        end else begin
            done <= start;
            if (start) begin
                result <= y0 + step_q[31:0];
                frac_out <= keep_frac ? prod[7:0] : 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    long_round_a: assert property (@(posedge clock) disable iff (!rst_n)
        (start && size == cso_pkg::SZ_L) |=> (done && frac_out == 8'h00))
        else $error("long interpolation left a fraction");
    ends_exact_a: assert property (@(posedge clock) disable iff (!rst_n)
        (start && frac == 8'h00) |=> (result == $past(y0)))
        else $error("zero fraction did not return lower entry");

endmodule

// ---- verilog/cso_pkg.sv ----
// Constants and types shared by the stack and special-operation core
package cso_pkg;

    // ------------------------------------------------------------
    // Command codes; codes above OP_LAST are unimplemented
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_PUSH = 4'h1,
        OP_PULL = 4'h2,
        OP_CALL = 4'h3,
        OP_RET = 4'h4,
        OP_TRAP = 4'h5,
        OP_PRE = 4'h6,
        OP_POST = 4'h7,
        OP_LOW_POWER_HALT = 4'h8,
        OP_TABLE_INTERPOLATE = 4'h9,
        OP_READ = 4'hA
    } cso_op_e;
    localparam logic [3:0] OP_LAST = 4'hA;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_MEM1 = 3'h1,
        ST_MEM2 = 3'h2,
        ST_CALC = 3'h3,
        ST_STOP = 3'h4
    } cso_state_e;

    // ------------------------------------------------------------
    // Operand sizes, status fields, register file layout
    // ------------------------------------------------------------
    localparam logic [1:0] SZ_B = 2'h0;
    localparam logic [1:0] SZ_W = 2'h1;
    localparam logic [1:0] SZ_L = 2'h2;
    localparam int SR_S_BIT = 13;
    localparam int SR_MASK_LO = 8;
    localparam logic [15:0] SR_RST = 16'h2700;
    localparam logic [2:0] REG_STACK_PTR = 3'h7;
    localparam logic [3:0] IDX_USER_PTR = 4'h7;
    localparam logic [3:0] IDX_SUPERVISOR_PTR = 4'h8;
    localparam int AREG_NUM = 9;
    localparam logic [31:0] AREG_RST = 32'h0000_0000;
    localparam logic [31:0] STEP_B = 32'h0000_0001;
    localparam logic [31:0] STEP_W = 32'h0000_0002;
    localparam logic [31:0] STEP_L = 32'h0000_0004;
    localparam logic [33:0] ROUND_HALF = 34'h0_0000_0080;
    localparam int FRAC_W = 8;

endpackage
